/* File: include/sadc_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// carrier between register file, pin mux and settle timer
// ****************************************************************
interface sadc_if import sadc_pkg::*;;
   logic [NPIN-1:0] pin_en;
   logic [NPIN-1:0] port_out;
   logic [NPIN-1:0] port_dir;
   logic [NPIN-1:0] port_rd;
   logic [CHAN_W-1:0] chan;
   logic restart;
   logic settled;

   modport ctl(output pin_en, output port_out, output port_dir,
      output chan, output restart, input port_rd, input settled);
   modport mux(input pin_en, input port_out, input port_dir,
      input chan, output port_rd);
   modport tmr(input restart, output settled);
endinterface : sadc_if

/* File: include/sadc_pkg.sv */
// ****************************************************************
// software converter constants
// ****************************************************************
package sadc_pkg;

   // clock and settling time of one comparison
   localparam int CLK_PERIOD_NS = 25;
   localparam int SETTLE_MAX_NS = 9000;
   // longest time rounds down to whole cycles
   localparam int SETTLE_CYC = SETTLE_MAX_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

   // register indices; byte address is four times the index
   localparam int IDX_CONV = 20;
   localparam int IDX_PINEN = 22;
   localparam int IDX_PORT = 40;
   localparam int IDX_PORTIN = 41;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CONV = ADDR_W'(4 * IDX_CONV);
   localparam logic [ADDR_W-1:0] ADDR_PINEN = ADDR_W'(4 * IDX_PINEN);
   localparam logic [ADDR_W-1:0] ADDR_PORT = ADDR_W'(4 * IDX_PORT);
   localparam logic [ADDR_W-1:0] ADDR_PORTIN = ADDR_W'(4 * IDX_PORTIN);

   // field layout
   localparam int NPIN = 3;
   localparam int REF_LSB = 0;
   localparam int REF_W = 4;
   localparam int CHAN_LSB = 4;
   localparam int CHAN_W = 2;
   localparam int SETTLED_BIT = 6;
   localparam int COMP_BIT = 7;
   localparam int PINEN_LSB = 0;
   localparam int PORT_OUT_LSB = 0;
   localparam int PORT_DIR_LSB = 4;
   localparam int PORTIN_LSB = 0;

   // reset values
   localparam logic [REF_W-1:0] REF_RST = 4'h0;
   localparam logic [CHAN_W-1:0] CHAN_RST = 2'h0;
   localparam logic [NPIN-1:0] PINEN_RST = 3'h0;
   localparam logic [NPIN-1:0] PORT_RST = 3'h0;

   // channel codes
   localparam logic [CHAN_W-1:0] CHAN_RSVD = 2'h3;

   // settle timer states, gray along idle, settling, settled
   typedef enum logic [1:0] {
      SADC_ST_IDLE = 2'b00,
      SADC_ST_SETTLING = 2'b01,
      SADC_ST_SETTLED = 2'b11
   } sadc_state_t;

endpackage : sadc_pkg

/* File: rtl/sadc_pinmux.sv */
`timescale 1ns/1ps
// ****************************************************************
// shared pin mux: port line or converter input, per pin
// ****************************************************************
module sadc_pinmux import sadc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   sadc_if.mux mif,
   input wire logic [NPIN-1:0] port_line_in,
   output logic [NPIN-1:0] port_line_out,
   output logic [NPIN-1:0] port_line_oe,
   output logic [NPIN-1:0] analog_switch_en
);

   logic [NPIN-1:0] rd_ff;

   assign mif.port_rd = rd_ff;

   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      // an analog pin never drives, so the source is not loaded
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            port_line_oe[i] <= 1'b0;
            port_line_out[i] <= 1'b0;
            rd_ff[i] <= 1'b0;
            analog_switch_en[i] <= 1'b0;
         end else begin
            port_line_oe[i] <= mif.port_dir[i] & ~mif.pin_en[i]; // see [R1]
            port_line_out[i] <= mif.port_out[i];
            rd_ff[i] <= port_line_in[i] & ~mif.pin_en[i]; // see [R1]
            // code 11 matches no pin index and closes no switch
            analog_switch_en[i] <= mif.pin_en[i] &&
               (mif.chan == CHAN_W'(i)); // see [R4]
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_analog_no_drive;
      mif.pin_en[0] |=> !port_line_oe[0] && !rd_ff[0];
   endproperty
   a_analog_no_drive: assert property (p_analog_no_drive) // see [R1]
      else $error("analog pin still driven as port line");

   property p_rsvd_no_switch;
      mif.chan == CHAN_RSVD |=> analog_switch_en == '0;
   endproperty
   a_rsvd_no_switch: assert property (p_rsvd_no_switch) // see [R4]
      else $error("reserved channel code closed a switch");

   property p_switch_route;
      (mif.chan == 2'h1 && mif.pin_en[1]) |=> analog_switch_en == 3'h2;
   endproperty
   a_switch_route: assert property (p_switch_route) // see [R4]
      else $error("channel one not routed alone");

endmodule : sadc_pinmux

/* File: rtl/sadc_settle.sv */
`timescale 1ns/1ps
// ****************************************************************
// settle timer: flags when a comparison has had time to finish
// ****************************************************************
module sadc_settle import sadc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   sadc_if.tmr tif
);

   sadc_state_t state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic settled_ff;
   logic cnt_done;

   assign tif.settled = settled_ff;
   assign cnt_done = (state_ff == SADC_ST_SETTLING) && (cnt_ff == SETTLE_LAST);

   // waits the worst case settle time, so a flag read after it is sure
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= SADC_ST_IDLE;
      end else if (tif.restart) begin
         state_ff <= SADC_ST_SETTLING; // see [R7]
      end else begin
         case (state_ff)
            SADC_ST_IDLE: state_ff <= SADC_ST_SETTLING;
            SADC_ST_SETTLING: begin
               if (cnt_done) begin
                  state_ff <= SADC_ST_SETTLED;
               end
            end
            SADC_ST_SETTLED: state_ff <= SADC_ST_SETTLED;
            default: state_ff <= SADC_ST_IDLE;
         endcase
      end
   end

   // cycle counter, cleared on every restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if (tif.restart || state_ff != SADC_ST_SETTLING) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= CNT_W'(cnt_ff + 1'b1);
      end
   end

   // restart wins over completion in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settled_ff <= 1'b0;
      end else if (tif.restart) begin
         settled_ff <= 1'b0; // see [R7]
      end else if (cnt_done) begin
         settled_ff <= 1'b1; // see [R7]
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_settle_clear;
      tif.restart |=> !settled_ff;
   endproperty
   a_settle_clear: assert property (p_settle_clear) // see [R7]
      else $error("settled flag not cleared by restart");

   property p_settle_time;
      $rose(settled_ff) |-> $past(cnt_ff) == SETTLE_LAST;
   endproperty
   a_settle_time: assert property (p_settle_time) // see [R7]
      else $error("settled flag rose at wrong count");

   property p_settle_bound;
      state_ff == SADC_ST_SETTLING |-> ##[0:360] (settled_ff || tif.restart);
   endproperty
   a_settle_bound: assert property (p_settle_bound) // see [R7]
      else $error("settle took longer than worst case");

   c_settled: cover property ($rose(settled_ff));

endmodule : sadc_settle

/* File: rtl/sadc_top.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// [R1] shared pin is converter input when its pin-enable bit is set, else port
// [R2] reference code field drives the four-bit reference DAC
// [R3] comparator flag reads 1 when input above reference, 0 below
// [R4] channel code 00,01,10 routes input 0,1,2; code 11 routes nothing
// [R5] software selects channel, then loads midpoint code 1000
// [R6] software raises code on flag 1, lowers on 0, halving range
// [R7] comparison settles in 6 to 9 us; software waits before reading
// [R8] software takes final code as the conversion result
// [R9] flag is read-only live output; writes change only code and channel
module sadc_top import sadc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comparator_in,
   output logic [REF_W-1:0] reference_code,
   output logic [NPIN-1:0] analog_switch_en,
   input wire logic [NPIN-1:0] port_line_in,
   output logic [NPIN-1:0] port_line_out,
   output logic [NPIN-1:0] port_line_oe
);

   // ****************************************************************
   // storage
   // ****************************************************************
   logic [REF_W-1:0] ref_ff;
   logic [CHAN_W-1:0] chan_ff;
   logic [NPIN-1:0] pin_en_ff;
   logic [NPIN-1:0] port_out_ff;
   logic [NPIN-1:0] port_dir_ff;
   logic comp_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic setup_phase;
   logic wr_take;
   logic hit_conv;
   logic hit_pinen;
   logic hit_port;
   logic hit_portin;
   logic mapped;
   logic [31:0] rd_word;

   sadc_if bus_if ();

   // one setup cycle then one access cycle; no further waits
   assign setup_phase = psel & ~penable;
   // only the low byte lane carries register bits
   assign wr_take = psel & penable & pready_ff & pwrite & pstrb[0];
   assign hit_conv = (paddr == ADDR_CONV);
   assign hit_pinen = (paddr == ADDR_PINEN);
   assign hit_port = (paddr == ADDR_PORT);
   assign hit_portin = (paddr == ADDR_PORTIN);
   assign mapped = hit_conv | hit_pinen | hit_port | hit_portin;

   // outputs straight from flip-flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign reference_code = ref_ff; // see [R2]

   // carrier to the pin mux and settle timer
   assign bus_if.pin_en = pin_en_ff;
   assign bus_if.port_out = port_out_ff;
   assign bus_if.port_dir = port_dir_ff;
   assign bus_if.chan = chan_ff;
   // changing reference, channel or pin use starts a new settle
   assign bus_if.restart = wr_take & (hit_conv | hit_pinen); // see [R7]

   // ****************************************************************
   // apb handshake
   // ****************************************************************
   // ready one cycle after setup; drops after completion so a
   // back to back setup never sees a stale ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= psel & ~pready_ff;
      end
   end

   // unmapped addresses answer with an error, nothing is stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup_phase & ~mapped;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   // reserved bits read as zero
   always_comb begin
      rd_word = '0;
      if (hit_conv) begin
         rd_word[REF_LSB +: REF_W] = ref_ff;
         rd_word[CHAN_LSB +: CHAN_W] = chan_ff;
         rd_word[SETTLED_BIT] = bus_if.settled;
         rd_word[COMP_BIT] = comp_ff; // see [R3]
      end else if (hit_pinen) begin
         rd_word[PINEN_LSB +: NPIN] = pin_en_ff;
      end else if (hit_port) begin
         rd_word[PORT_OUT_LSB +: NPIN] = port_out_ff;
         rd_word[PORT_DIR_LSB +: NPIN] = port_dir_ff;
      end else if (hit_portin) begin
         rd_word[PORTIN_LSB +: NPIN] = bus_if.port_rd;
      end
   end

   // data captured in setup so it is a flop output during access;
   // the flag is therefore two cycles older than the live comparator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (setup_phase) begin
         prdata_ff <= pwrite ? 32'h0 : rd_word;
      end else if (pready_ff) begin
         prdata_ff <= '0;
      end
   end

   // ****************************************************************
   // comparator sample
   // ****************************************************************
   // live comparator level, no latching: a read shows the side two cycles back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_ff <= 1'b0;
      end else begin
         comp_ff <= comparator_in; // see [R9]
      end
   end

   // ****************************************************************
   // conversion register
   // ****************************************************************
   // flag and settled bits are not stored by a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_ff <= REF_RST;
         chan_ff <= CHAN_RST;
      end else if (wr_take && hit_conv) begin
         ref_ff <= pwdata[REF_LSB +: REF_W]; // see [R2]
         chan_ff <= pwdata[CHAN_LSB +: CHAN_W]; // see [R9]
      end
   end

   // ****************************************************************
   // pin enable and port line registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_en_ff <= PINEN_RST;
      end else if (wr_take && hit_pinen) begin
         pin_en_ff <= pwdata[PINEN_LSB +: NPIN]; // see [R1]
      end
   end

   // port line data and direction, used while a pin is a port line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_out_ff <= PORT_RST;
         port_dir_ff <= PORT_RST;
      end else if (wr_take && hit_port) begin
         port_out_ff <= pwdata[PORT_OUT_LSB +: NPIN];
         port_dir_ff <= pwdata[PORT_DIR_LSB +: NPIN];
      end
   end

   // ****************************************************************
   // pin mux and settle timer
   // ****************************************************************
   sadc_pinmux u_pinmux (
      .pclk(pclk),
      .presetn(presetn),
      .mif(bus_if.mux),
      .port_line_in(port_line_in),
      .port_line_out(port_line_out),
      .port_line_oe(port_line_oe),
      .analog_switch_en(analog_switch_en)
   );

   sadc_settle u_settle (
      .pclk(pclk),
      .presetn(presetn),
      .tif(bus_if.tmr)
   );

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ref_write;
      (wr_take && hit_conv) |=> reference_code == $past(pwdata[3:0]);
   endproperty
   a_ref_write: assert property (p_ref_write) // see [R2]
      else $error("reference code not taken from write");

   property p_ref_hold;
      !(wr_take && hit_conv) |=> $stable(reference_code);
   endproperty
   a_ref_hold: assert property (p_ref_hold) // see [R2]
      else $error("reference code changed without write");

   property p_flag_read;
      (psel && penable && pready && !pwrite && hit_conv)
         |-> prdata[COMP_BIT] == $past(comp_ff);
   endproperty
   a_flag_read: assert property (p_flag_read) // see [R3]
      else $error("read flag does not match comparator");

   property p_flag_live;
      ##1 comp_ff == $past(comparator_in);
   endproperty
   a_flag_live: assert property (p_flag_live) // see [R9]
      else $error("flag not following comparator");

   property p_conv_write_only;
      (wr_take && hit_conv) |=> $stable(pin_en_ff) && $stable(port_dir_ff);
   endproperty
   a_conv_write_only: assert property (p_conv_write_only) // see [R9]
      else $error("conversion write touched other fields");

   property p_pinen_write;
      (wr_take && hit_pinen) |=> ##1 (port_line_oe & pin_en_ff) == '0;
   endproperty
   a_pinen_write: assert property (p_pinen_write) // see [R1]
      else $error("enabled analog pin still drives");

   property p_ready_after_setup;
      setup_phase |=> pready && (pslverr == !$past(mapped));
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("access not answered after setup");

   // strobe and field checks
   property p_strb_ignored;
      (psel && penable && pready && pwrite && !pstrb[0])
         |=> $stable(reference_code) && $stable(pin_en_ff);
   endproperty
   a_strb_ignored: assert property (p_strb_ignored) // see [R9]
      else $error("write without low byte strobe was stored");

   property p_code_read;
      (psel && penable && pready && !pwrite && hit_conv)
         |-> prdata[REF_LSB +: REF_W] == reference_code;
   endproperty
   a_code_read: assert property (p_code_read) // see [R2]
      else $error("read code field does not match reference");

   // a write that changes the code must void the old comparison
   property p_conv_restart;
      (wr_take && hit_conv) |=> !bus_if.settled;
   endproperty
   a_conv_restart: assert property (p_conv_restart) // see [R7]
      else $error("conversion write did not restart settle");

   property p_settled_read;
      (psel && penable && pready && !pwrite && hit_conv)
         |-> prdata[SETTLED_BIT] == $past(bus_if.settled);
   endproperty
   a_settled_read: assert property (p_settled_read) // see [R7]
      else $error("read settled bit does not match timer");

   // stale data outside an access would mislead a polling loop
   property p_rdata_idle;
      !penable |-> prdata == '0 && !pslverr;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data or error shown outside access");

   // one access cycle only, so a back to back setup starts clean
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("ready held longer than one cycle");

   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error shown without ready");

   // main scenarios: code write, flag seen high, refused address
   c_conv_write: cover property (wr_take && hit_conv);
   c_flag_high: cover property (psel && penable && pready && hit_conv &&
      !pwrite && prdata[COMP_BIT]);
   c_bad_addr: cover property (pslverr);

endmodule : sadc_top

/* File: tb/sadc_analog_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// analog sources and comparator behind the shared pins
// ****************************************************************
module sadc_analog_model import sadc_pkg::*; (
   input wire logic pclk,
   input wire logic [NPIN-1:0] analog_switch_en,
   input wire logic [REF_W-1:0] reference_code,
   input wire logic [NPIN-1:0][5:0] levels,
   output logic comparator_in
);
   // levels and reference both count in 1/32 of the supply
   localparam int SLOW_CYC = 240; // 6 us at 25 ns per cycle
   logic [7:0] age_ff = 8'h00;
   logic [NPIN-1:0] sw_ff = 3'h0;
   logic [REF_W-1:0] code_ff = 4'h0;
   logic wiggle_ff = 1'b0;
   logic above;

   // age since the last switch or code change; reset on every change
   always_ff @(posedge pclk) begin
      sw_ff <= analog_switch_en;
      code_ff <= reference_code;
      wiggle_ff <= ~wiggle_ff;
      if (sw_ff != analog_switch_en || code_ff != reference_code) begin
         age_ff <= 8'h00;
      end else if (age_ff != 8'hff) begin
         age_ff <= age_ff + 8'h01;
      end
   end

   // open switches float the comparator; unsettled output is inverted
   always_comb begin
      above = wiggle_ff;
      for (int i = 0; i < NPIN; i++) begin
         if (analog_switch_en == NPIN'(1 << i)) begin
            above = {1'b0, levels[i]} >
               {2'h0, reference_code, 1'b0} + 7'h02;
         end
      end
      comparator_in = (age_ff < SLOW_CYC) ? ~above : above;
   end
endmodule : sadc_analog_model

/* File: tb/tb_software_adc_control.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench for the software converter control
// ****************************************************************
module tb_software_adc_control import sadc_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic comparator_in;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] pstrb;
   logic [REF_W-1:0] reference_code;
   logic [NPIN-1:0] analog_switch_en, port_line_in;
   logic [NPIN-1:0] port_line_out, port_line_oe;
   logic [NPIN-1:0][5:0] levels;
   int mismatches = 0;
   int n_compared = 0;

   sadc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_in(comparator_in), .reference_code(reference_code),
      .analog_switch_en(analog_switch_en), .port_line_in(port_line_in),
      .port_line_out(port_line_out), .port_line_oe(port_line_oe));
   sadc_analog_model model (.pclk(pclk),
      .analog_switch_en(analog_switch_en),
      .reference_code(reference_code), .levels(levels),
      .comparator_in(comparator_in));

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic report_and_stop();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one apb transfer; ready, read data and error taken at a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            mismatches++;
            report_and_stop();
         end
         @(posedge pclk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask : rd

   // pins follow the registers one cycle late
   task automatic settle_pins();
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : settle_pins

   function automatic logic [3:0] exp_code(input logic [5:0] lvl);
      logic [3:0] r;
      r = 4'h0;
      for (int c = 0; c < 16; c++) begin
         if (int'(lvl) > 2 * (c + 1)) r = 4'(c);
      end
      return r;
   endfunction : exp_code

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      rd(ADDR_CONV);
      chk("conv after reset", rdata & 32'h7f, 32'h0);
      chk("conv read error", 32'(rerr), 32'h0);
      chk("code pins after reset", 32'(reference_code), 32'h0);
      rd(ADDR_PINEN);
      chk("pin enable after reset", rdata, 32'h0);
      rd(8'hfc);
      chk("unmapped error", 32'(rerr), 32'h1);
      chk("unmapped data", rdata, 32'h0);
   endtask : t_reset

   task automatic t_port_mode();
      @(posedge pclk);
      port_line_in <= 3'h6;
      wr(ADDR_PINEN, 32'h0);
      wr(ADDR_PORT, 32'h75);
      settle_pins();
      chk("oe port mode", 32'(port_line_oe), 32'h7);
      chk("out port mode", 32'(port_line_out), 32'h5);
      rd(ADDR_PORTIN);
      chk("port input", rdata, 32'h6);
      wr(ADDR_PINEN, 32'h5);
      settle_pins();
      chk("oe analog pins", 32'(port_line_oe), 32'h2);
      rd(ADDR_PORTIN);
      chk("port input analog", rdata, 32'h2);
   endtask : t_port_mode

   // each entry: pin enable, channel code, expected switches
   task automatic t_chan_sel();
      logic [7:0] tab [6];
      tab = '{8'he1, 8'hea, 8'hf4, 8'hf8, 8'ha8, 8'h4a};
      foreach (tab[i]) begin
         wr(ADDR_PINEN, 32'(tab[i][7:5]));
         wr(ADDR_CONV, 32'(tab[i][4:3]) << CHAN_LSB);
         settle_pins();
         chk("switches", 32'(analog_switch_en),
            32'(tab[i][2:0]));
      end
   endtask : t_chan_sel

   task automatic t_fields();
      wr(ADDR_CONV, 32'hffff_ffe5);
      rd(ADDR_CONV);
      chk("conv fields", rdata & 32'hffff_ff7f, 32'h25);
      chk("code pins", 32'(reference_code), 32'h5);
      apb(1'b1, ADDR_CONV, 32'h0, 4'h0);
      rd(ADDR_CONV);
      chk("conv unstrobed write", rdata & 32'h3f, 32'h25);
   endtask : t_fields

   // software search, halving the range on every settled comparison
   task automatic t_convert(input int ch);
      logic [3:0] code;
      logic [31:0] cb;
      logic above;
      int n;
      cb = 32'(ch) << CHAN_LSB;
      wr(ADDR_CONV, cb);
      code = 4'h8;
      for (int b = 3; b >= 0; b--) begin
         wr(ADDR_CONV, cb | 32'(code));
         n = 0;
         rd(ADDR_CONV);
         while (rdata[SETTLED_BIT] !== 1'b1) begin
            n++;
            if (n > 400) begin
               mismatches++;
               report_and_stop();
            end
            rd(ADDR_CONV);
         end
         above = int'(levels[ch]) > 2 * (int'(code) + 1);
         chk("flag", 32'(rdata[COMP_BIT]), 32'(above));
         if (rdata[COMP_BIT] !== 1'b1) code[b] = 1'b0;
         if (b > 0) code[b-1] = 1'b1;
      end
      wr(ADDR_CONV, cb | 32'(code));
      settle_pins();
      chk("result", 32'(code), 32'(exp_code(levels[ch])));
      chk("final code pins", 32'(reference_code), 32'(code));
   endtask : t_convert

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      port_line_in = 3'h0;
      levels = {6'h01, 6'h1f, 6'h0b};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_port_mode();
      t_chan_sel();
      t_fields();
      wr(ADDR_PINEN, 32'h7);
      for (int ch = 0; ch < NPIN; ch++) begin
         t_convert(ch);
      end
      report_and_stop();
   end
endmodule : tb_software_adc_control
